/* File: rtl/usb_desc_engine.sv */
// descriptor status handling between firmware and the serial interface engine
`timescale 1ns/1ps
`default_nettype none
module usb_desc_engine (
    // clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    sys_rst,
    // register bus
    input  wire logic [usb_desc_pkg::ADDR_W-1:0]         avs_address,
    input  wire logic                                    avs_read,
    input  wire logic                                    avs_write,
    input  wire logic [usb_desc_pkg::DATA_W-1:0]         avs_writedata,
    input  wire logic [3:0]                              avs_byteenable,
    output var  logic [usb_desc_pkg::DATA_W-1:0]         avs_readdata,
    output var  logic                                    avs_waitrequest,
    // token side
    input  wire logic                                    tok_valid,
    input  wire usb_desc_pkg::token_t                    tok,
    output var  logic                                    tok_ready,
    output var  logic                                    rep_valid,
    output var  usb_desc_pkg::reply_t                    rep,
    // interrupt
    output var  logic                                    irq
);
    import usb_desc_pkg::*;

    eng_t                eng_q, eng_d;
    bus_t                bus_q, bus_d;
    token_t              tok_q;
    reply_t              rep_q, rep_d;
    logic                rep_valid_q;
    logic                tok_ready_q;
    logic                wait_q;
    logic [DATA_W-1:0]   rdata_q, rd_d;
    logic [TRANSACTION_STATUS_REGISTER_W-1:0]  transaction_status_register_q;
    logic [IRQ_W-1:0]    istat_q, istat_d, imask_q;
    logic                irq_q;

    // memory port
    logic                mem_en, mem_we;
    logic [IDX_W-1:0]    mem_addr;
    logic [DATA_W-1:0]   mem_wdata, mem_rdata;

    desc_mem #(
        .WIDTH (DATA_W),
        .DEPTH (NUM_DESC),
        .AW    (IDX_W)
    ) u_mem (
        .clk     (clk),
        .en      (mem_en),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (mem_wdata),
        .rdata_q (mem_rdata)
    );

    // fields of the fetched descriptor
    wire       own      = mem_rdata[STAT_LSB + OWN_BIT];
    wire       tog      = mem_rdata[STAT_LSB + TOG_BIT];
    wire       toggle_sync_enable      = mem_rdata[STAT_LSB + DTS_BIT];
    wire       stall    = mem_rdata[STAT_LSB + STALL_BIT];
    wire [7:0] d_cnt    = mem_rdata[CNT_LSB +: 8];
    wire [7:0] d_baddr  = mem_rdata[BADDR_LSB +: 8];

    wire take_tok  = tok_valid & tok_ready_q;
    wire in_dec    = (eng_q == E_DEC);
    // check only when enabled, mismatch detect
    wire tog_bad   = toggle_sync_enable & ~tok_q.dir_in & (tok_q.toggle != tog);
    // owner zero: nothing else is looked at
    wire complete  = own & ~stall & ~tog_bad;

    // not owned first gives nak, then stall, toggle from descriptor
    wire hs_t  hs_sel = ~own   ? HS_NAK   :
                        stall  ? HS_STALL :
                        tok_q.dir_in ? HS_DATA : HS_ACK;
    assign rep_d = '{hs: hs_sel,
                     toggle: tog,
                     commit: complete & ~tok_q.dir_in,
                     count: tok_q.dir_in ? d_cnt : tok_q.count,
                     baddr: d_baddr};

    // pid, toggle and count written back with owner cleared
    wire       new_tog  = tok_q.dir_in ? tog : tok_q.toggle;
    wire [7:0] new_cnt  = tok_q.dir_in ? d_cnt : tok_q.count;
    wire [7:0] new_stat = {1'b0, new_tog, tok_q.pid, 2'b00};
    wire [DATA_W-1:0] eng_wdata = {8'h00, d_baddr, new_cnt, new_stat};

    always_comb begin
        eng_d = eng_q;
        case (eng_q)
            E_IDLE: begin
                if (take_tok) begin
                    eng_d = E_FETCH;
                end
            end
            E_FETCH: eng_d = E_DEC;
            // stalled or foreign descriptor is left untouched
            E_DEC: eng_d = complete ? E_WRITE : E_IDLE;
            E_WRITE: eng_d = E_IDLE;
            default: eng_d = E_IDLE;
        endcase
    end

    // bus decode
    wire       bus_req   = avs_read | avs_write;
    wire [5:0] word_idx  = avs_address[7:2];
    wire       desc_hit  = (word_idx < DESC_WORDS);
    wire       hit_transaction_status_register = (avs_address == TRANSACTION_STATUS_REGISTER_OFS);
    wire       hit_istat = (avs_address == IRQ_STAT_OFS);
    wire       hit_imask = (avs_address == IRQ_MASK_OFS);
    wire       bus_go    = (bus_q == B_IDLE) & bus_req & (eng_q == E_IDLE) & ~tok_valid;
    wire       bus_done  = (bus_d == B_ACK) & (bus_q != B_ACK);
    wire       reg_wr    = bus_done & avs_write;

    always_comb begin
        bus_d = bus_q;
        case (bus_q)
            B_IDLE: begin
                if (bus_go) begin
                    bus_d = desc_hit ? B_RD : B_ACK;
                end
            end
            B_RD:   bus_d = B_MOD;
            B_MOD:  bus_d = B_ACK;
            B_ACK:  bus_d = B_IDLE;
            default: bus_d = B_IDLE;
        endcase
    end

    // reserved status positions of bus write data never reach storage
    wire [DATA_W-1:0] wd_clean = {8'h00, avs_writedata[23:8],
                                  avs_writedata[7:0] & STAT_WR_MASK};
    wire [DATA_W-1:0] be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [DATA_W-1:0] bus_wdata = (mem_rdata & ~be_mask) | (wd_clean & be_mask);

    wire bus_mem  = (bus_q == B_RD) | ((bus_q == B_MOD) & avs_write);
    wire bus_wr   = (bus_q == B_MOD) & avs_write;
    assign mem_en    = (eng_q == E_FETCH) | (eng_q == E_WRITE) | bus_mem;
    assign mem_we    = (eng_q == E_WRITE) | bus_wr;
    assign mem_addr  = (bus_q != B_IDLE) ? avs_address[4:2] : tok_q.idx;
    assign mem_wdata = bus_wr ? bus_wdata : eng_wdata;

    // read data selection
    assign rd_d = (bus_q == B_MOD) ? {8'h00, mem_rdata[23:0]} :
                  hit_transaction_status_register ? DATA_W'(transaction_status_register_q) :
                  hit_istat ? DATA_W'(istat_q) :
                  hit_imask ? DATA_W'(imask_q) : '0;

    // interrupt events, set wins over write-one clear
    wire [IRQ_W-1:0] ev  = {in_dec & own & ~stall & tog_bad,
                            in_dec & own & stall,
                            in_dec & complete};
    wire [IRQ_W-1:0] clr = (reg_wr & hit_istat) ? avs_writedata[IRQ_W-1:0] : '0;
    assign istat_d = (istat_q & ~clr) | ev;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eng_q       <= E_IDLE;
            bus_q       <= B_IDLE;
            tok_q       <= '0;
            rep_q       <= '0;
            rep_valid_q <= 1'b0;
            tok_ready_q <= 1'b0;
            wait_q      <= 1'b1;
            rdata_q     <= '0;
            transaction_status_register_q     <= '0;
            istat_q     <= '0;
            imask_q     <= '0;
            irq_q       <= 1'b0;
        end else begin
            eng_q       <= eng_d;
            bus_q       <= bus_d;
            tok_ready_q <= (eng_d == E_IDLE) & (bus_d == B_IDLE);
            rep_valid_q <= in_dec;
            wait_q      <= ~bus_done;
            istat_q     <= istat_d;
            irq_q       <= |(istat_d & imask_q);
            if (take_tok) begin
                tok_q <= tok;
            end
            if (in_dec) begin
                rep_q <= rep_d;
            end
            // transaction status updated ahead of the owner clear
            if (in_dec && complete) begin
                transaction_status_register_q <= {tok_q.idx, tok_q.dir_in};
            end
            if (bus_done) begin
                rdata_q <= rd_d;
            end
            if (reg_wr && hit_imask) begin
                imask_q <= avs_writedata[IRQ_W-1:0];
            end
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign tok_ready       = tok_ready_q;
    assign rep_valid       = rep_valid_q;
    assign rep             = rep_q;
    assign irq             = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_stall_reply;
        (in_dec && own && stall) |=> (rep_valid_q && rep_q.hs == HS_STALL);
    endproperty
    a_stall_reply: assert property (p_stall_reply)
        else $error("stall bit did not give a stall reply");

    property p_stall_keep;
        (in_dec && own && stall) |=> (eng_q == E_IDLE && !mem_we);
    endproperty
    a_stall_keep: assert property (p_stall_keep)
        else $error("stalled descriptor was written");

    property p_not_owned;
        (in_dec && !own) |=> (rep_q.hs == HS_NAK && !rep_q.commit && !mem_we);
    endproperty
    a_not_owned: assert property (p_not_owned)
        else $error("descriptor not owned was used");

    property p_own_clear;
        (eng_q == E_WRITE) |-> (mem_we && !mem_wdata[STAT_LSB + OWN_BIT]);
    endproperty
    a_own_clear: assert property (p_own_clear)
        else $error("owner flag not cleared on completion");

    property p_tog_drop;
        (in_dec && own && !stall && tog_bad) |=> (!rep_q.commit && !mem_we);
    endproperty
    a_tog_drop: assert property (p_tog_drop)
        else $error("mismatched toggle packet was committed");

    property p_no_check;
        (in_dec && own && !stall && !toggle_sync_enable && !tok_q.dir_in) |=> (rep_q.commit && mem_we);
    endproperty
    a_no_check: assert property (p_no_check)
        else $error("toggle checked while disabled");

    property p_in_toggle;
        (in_dec && own && !stall && tok_q.dir_in)
            |=> (rep_q.hs == HS_DATA && rep_q.toggle == $past(tog));
    endproperty
    a_in_toggle: assert property (p_in_toggle)
        else $error("in reply toggle differs from descriptor");

    property p_status_first;
        (eng_q == E_WRITE) |-> (transaction_status_register_q == {tok_q.idx, tok_q.dir_in} && $past(in_dec));
    endproperty
    a_status_first: assert property (p_status_first)
        else $error("transaction status not updated before write-back");

    property p_pid_view;
        (eng_q == E_WRITE) |-> (mem_wdata[STAT_LSB + PID_LSB +: PID_W] == tok_q.pid);
    endproperty
    a_pid_view: assert property (p_pid_view)
        else $error("token identifier missing from status byte");

    property p_rsvd_ignored;
        (bus_wr && avs_byteenable[0]) |-> ((mem_wdata[7:0] & ~STAT_WR_MASK) == 8'h00);
    endproperty
    a_rsvd_ignored: assert property (p_rsvd_ignored)
        else $error("reserved status bits were stored");

    property p_own_gate;
        (in_dec && !own) |=> (eng_q == E_IDLE);
    endproperty
    a_own_gate: assert property (p_own_gate)
        else $error("engine went on with a descriptor it does not own");

    property p_transaction_status_register_hold;
        (in_dec && !complete) |=> $stable(transaction_status_register_q);
    endproperty
    a_transaction_status_register_hold: assert property (p_transaction_status_register_hold)
        else $error("transaction status changed without a completion");

    property p_done_irq;
        (in_dec && complete) |=> istat_q[IRQ_DONE];
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("completion did not raise the done status bit");

    property p_stall_irq;
        (in_dec && own && stall) |=> istat_q[IRQ_STALL];
    endproperty
    a_stall_irq: assert property (p_stall_irq)
        else $error("stall answer did not raise its status bit");

    property p_tog_irq;
        (in_dec && own && !stall && tog_bad) |=> istat_q[IRQ_TOGERR];
    endproperty
    a_tog_irq: assert property (p_tog_irq)
        else $error("toggle drop did not raise its status bit");

    property p_check_pass;
        (in_dec && own && !stall && toggle_sync_enable && !tok_q.dir_in && tok_q.toggle == tog)
            |=> (rep_q.commit && mem_we);
    endproperty
    a_check_pass: assert property (p_check_pass)
        else $error("matching toggle was refused by the check");

    property p_out_wb;
        (eng_q == E_WRITE && !tok_q.dir_in)
            |-> (mem_wdata[CNT_LSB +: 8] == tok_q.count
                 && mem_wdata[STAT_LSB + TOG_BIT] == tok_q.toggle);
    endproperty
    a_out_wb: assert property (p_out_wb)
        else $error("out write-back lost count or toggle");

    property p_mem_share;
        (eng_q != E_IDLE) |-> (bus_q == B_IDLE);
    endproperty
    a_mem_share: assert property (p_mem_share)
        else $error("bus and engine used the memory together");

    property p_ready_busy;
        (eng_q != E_IDLE) |-> !tok_ready_q;
    endproperty
    a_ready_busy: assert property (p_ready_busy)
        else $error("token ready while the engine is busy");

    property p_wait_one;
        (!wait_q) |=> wait_q;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for more than one cycle");

    c_stall: cover property (in_dec && own && stall);
    c_tog_drop: cover property (in_dec && own && !stall && tog_bad);
    c_in_done: cover property (in_dec && complete && tok_q.dir_in ##1 eng_q == E_WRITE);
    c_irq: cover property ($rose(irq_q));
    c_out_done: cover property (in_dec && complete && !tok_q.dir_in);

endmodule : usb_desc_engine
`default_nettype wire

/* File: rtl/usb_desc_pkg.sv */
// shared constants and types for the descriptor status engine
package usb_desc_pkg;

    localparam int NUM_DESC   = 6;
    localparam int IDX_W      = 3;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int PID_W      = 4;
    localparam int IRQ_W      = 3;
    localparam int TRANSACTION_STATUS_REGISTER_W    = IDX_W + 1;

    // status byte bit positions
    localparam int OWN_BIT    = 7;
    localparam int TOG_BIT    = 6;
    localparam int DTS_BIT    = 3;
    localparam int STALL_BIT  = 2;
    localparam int PID_LSB    = 2;

    // descriptor word layout
    localparam int STAT_LSB   = 0;
    localparam int CNT_LSB    = 8;
    localparam int BADDR_LSB  = 16;

    // writable positions of the written status byte
    localparam logic [7:0] STAT_WR_MASK = 8'hcc;

    // register map, byte addresses
    localparam logic [ADDR_W-1:0] DESC_BASE_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] TRANSACTION_STATUS_REGISTER_OFS     = 8'h20;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS  = 8'h24;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS  = 8'h28;
    localparam logic [5:0]        DESC_WORDS    = 6'h06;

    // interrupt bits
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_STALL  = 1;
    localparam int IRQ_TOGERR = 2;

    typedef enum logic [2:0] {
        HS_NONE  = 3'h0,
        HS_ACK   = 3'h1,
        HS_NAK   = 3'h2,
        HS_STALL = 3'h3,
        HS_DATA  = 3'h4
    } hs_t;

    typedef enum logic [3:0] {
        E_IDLE  = 4'h1,
        E_FETCH = 4'h2,
        E_DEC   = 4'h4,
        E_WRITE = 4'h8
    } eng_t;

    typedef enum logic [3:0] {
        B_IDLE = 4'h1,
        B_RD   = 4'h2,
        B_MOD  = 4'h4,
        B_ACK  = 4'h8
    } bus_t;

    typedef struct packed {
        logic [IDX_W-1:0] idx;
        logic [PID_W-1:0] pid;
        logic             dir_in;
        logic             toggle;
        logic [7:0]       count;
    } token_t;

    typedef struct packed {
        hs_t        hs;
        logic       toggle;
        logic       commit;
        logic [7:0] count;
        logic [7:0] baddr;
    } reply_t;

endpackage : usb_desc_pkg

/* File: rtl/desc_mem.sv */
// descriptor table storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module desc_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 6,
    parameter int AW    = 3
) (
    // clock
    input  wire logic             clk,
    // access port
    input  wire logic             en,
    input  wire logic             we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output var  logic [WIDTH-1:0] rdata_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
        if (en) begin
            rdata_q <= mem[addr];
        end
    end
endmodule : desc_mem
`default_nettype wire

/* File: tb/usb_host_model.sv */
// host stand-in that issues tokens and collects replies
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
    // clock
    input  wire logic                  clk,
    // token out
    output var  usb_desc_pkg::token_t  tok,
    output var  logic                  tok_valid,
    input  wire logic                  tok_ready,
    // reply in
    input  wire logic                  rep_valid,
    input  wire usb_desc_pkg::reply_t  rep
);
    import usb_desc_pkg::*;

    initial begin
        tok_valid = 1'b0;
        tok = '0;
    end

    // hold token until taken, then wait for its reply
    task automatic send(input token_t t, output reply_t r);
        @(posedge clk);
        tok_valid <= 1'b1;
        tok <= t;
        @(posedge clk);
        while (tok_ready !== 1'b1) @(posedge clk);
        tok_valid <= 1'b0;
        tok <= ~t;
        @(posedge clk);
        while (rep_valid !== 1'b1) @(posedge clk);
        r = rep;
    endtask : send
endmodule : usb_host_model
`default_nettype wire

/* File: tb/usb_desc_engine_test.sv */
// randomised checks of descriptor ownership, stall and toggle handling
`timescale 1ns/1ps
`default_nettype none
module usb_desc_engine_test;
    import usb_desc_pkg::*;
    logic               clk;
    logic               sys_rst;
    logic [ADDR_W-1:0]  avs_address;
    logic               avs_read;
    logic               avs_write;
    logic [DATA_W-1:0]  avs_writedata;
    logic [3:0]         avs_byteenable;
    logic [DATA_W-1:0]  avs_readdata;
    logic               avs_waitrequest;
    logic               tok_valid;
    token_t             tok;
    logic               tok_ready;
    logic               rep_valid;
    reply_t             rep;
    logic               irq;
    int                 mismatches;
    int                 checks;
    int                 cycles;
    logic [31:0]        seed;

    usb_desc_engine u_usb_desc_engine (.clk(clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tok_valid(tok_valid), .tok(tok), .tok_ready(tok_ready),
        .rep_valid(rep_valid), .rep(rep), .irq(irq));

    usb_host_model u_usb_host_model (.clk(clk), .tok(tok), .tok_valid(tok_valid),
        .tok_ready(tok_ready), .rep_valid(rep_valid), .rep(rep));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // event bits a token should raise: done, stall, toggle drop
    function automatic logic [2:0] exp_ev(input logic [7:0] s, input token_t t);
        if (!s[OWN_BIT]) return 3'h0;
        if (s[STALL_BIT]) return 3'h2;
        if (!t.dir_in && s[DTS_BIT] && t.toggle != s[TOG_BIT]) return 3'h4;
        return 3'h1;
    endfunction : exp_ev

    function automatic logic [2:0] exp_hs(input logic [2:0] ev, input logic dir_in);
        case (ev)
            3'h0: return HS_NAK;
            3'h2: return HS_STALL;
            3'h4: return HS_ACK;
            default: return dir_in ? HS_DATA : HS_ACK;
        endcase
    endfunction : exp_hs

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_byteenable <= be;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic final_report();
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    initial begin
        logic [31:0] q;
        logic [31:0] w;
        logic [7:0]  s;
        logic [7:0]  a;
        logic [2:0]  ev;
        logic [2:0]  m;
        token_t      t;
        reply_t      p;
        logic [7:0]  corner [3];
        seed = 32'hbcbf6fdd;
        corner = '{8'hff, 8'hc8, 8'h88};
        mismatches = 0;
        checks = 0;
        cycles = 0;
        sys_rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = '0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(irq, 0);
        bus(1'b1, 8'h30, 4'hf, 32'hffffffff, q);
        bus(1'b0, 8'h30, 4'hf, 0, q);
        chk(q, 0);
        for (int i = 0; i < 60; i++) begin
            w = rnd();
            t = w[18:0];
            t.idx = 3'(w[31:19] % NUM_DESC);
            w = rnd();
            s = w[7:0];
            s[OWN_BIT] = (w[9:8] != 2'h0);
            s[STALL_BIT] = (w[11:10] == 2'h0);
            if (i < 3) s = corner[i];
            if (i == 1) t.dir_in = 1'b1;
            if (i == 2) t = '{idx: t.idx, pid: t.pid, dir_in: 1'b0, toggle: 1'b1, count: t.count};
            m = 3'(rnd());
            a = {3'h0, t.idx, 2'h0};
            ev = exp_ev(s, t);
            bus(1'b1, a, 4'he, w, q);
            bus(1'b1, a, 4'h1, {24'h0, s}, q);
            bus(1'b1, IRQ_MASK_OFS, 4'hf, {29'h0, m}, q);
            u_usb_host_model.send(t, p);
            chk(p.hs, exp_hs(ev, t.dir_in));
            if (!t.dir_in && ev[0]) chk(p.commit, 1);
            if (!t.dir_in && ev[2]) chk(p.commit, 0);
            if (t.dir_in && ev[0]) chk({p.toggle, p.count, p.baddr}, {s[TOG_BIT], w[15:8], w[23:16]});
            bus(1'b0, IRQ_STAT_OFS, 4'hf, 0, q);
            chk(q, {29'h0, ev});
            chk(irq, |(ev & m));
            bus(1'b1, IRQ_STAT_OFS, 4'hf, 32'h7, q);
            bus(1'b0, a, 4'hf, 0, q);
            chk(irq, 0);
            if (ev == 3'h1 && t.dir_in) begin
                chk(q & 32'hfffffffc, {8'h0, w[23:8], 1'b0, s[TOG_BIT], t.pid, 2'h0});
            end else if (ev == 3'h1) begin
                chk(q, {8'h0, w[23:16], t.count, 1'b0, t.toggle, t.pid, 2'h0});
            end else begin
                chk(q, {8'h0, w[23:8], s & STAT_WR_MASK});
            end
            if (ev == 3'h1) begin
                bus(1'b0, TRANSACTION_STATUS_REGISTER_OFS, 4'hf, 0, q);
                chk(q, {28'h0, t.idx, t.dir_in});
            end
        end
        final_report();
    end
endmodule : usb_desc_engine_test
`default_nettype wire
